// ---- glcs_cfg.sv ----
// Gain loop and carrier sense configuration registers with carrier sense decision
// ***************************************************************
// ***************************************************************
`include "glcs_defs.svh"
`default_nettype none
module glcs_cfg
    import glcs_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [`GLCS_ADDR_W-1:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rd_data,
    output logic reg_rd_valid,
    input wire logic [7:0] rssi_db,
    input wire logic cs_restart,
    output glcs_gain_cfg_s gain_cfg,
    output logic [5:0] setpoint_db,
    output logic carrier_sense
);

    // ***************************************************************
    // Lookups
    // ***************************************************************
    function automatic logic [5:0] setpoint_to_db(input logic [2:0] code);
        unique case (code)
            3'h0: setpoint_to_db = 6'h18;
            3'h1: setpoint_to_db = 6'h1B;
            3'h2: setpoint_to_db = 6'h1E;
            3'h3: setpoint_to_db = 6'h21;
            3'h4: setpoint_to_db = 6'h24;
            3'h5: setpoint_to_db = 6'h26;
            3'h6: setpoint_to_db = 6'h28;
            3'h7: setpoint_to_db = 6'h2A;
        endcase
    endfunction

    function automatic logic [3:0] rise_step_db(input logic [1:0] code);
        unique case (code)
            2'h0: rise_step_db = 4'h0;
            2'h1: rise_step_db = 4'h6;
            2'h2: rise_step_db = 4'hA;
            2'h3: rise_step_db = 4'hE;
        endcase
    endfunction

    glcs_state_s state_reg;
    glcs_state_s state_next;

    logic [1:0] rel_code;
    logic [3:0] abs_code;
    logic rel_on;
    logic abs_on;
    logic [7:0] rise_db;
    logic rel_hit;
    logic signed [9:0] level_thr;
    logic abs_hit;
    logic cs_next;

    assign rel_code = state_reg.gain_order_and_sense_thresholds_reg[`GLCS_REL_HI:`GLCS_REL_LO];
    assign abs_code = state_reg.gain_order_and_sense_thresholds_reg[`GLCS_ABS_HI:`GLCS_ABS_LO];

    // ***************************************************************
    // Carrier sense decision
    // ***************************************************************
    // rise and level sensing enables
    assign rel_on = (rel_code != 2'h0);
    assign abs_on = (abs_code != `GLCS_ABS_OFF);
    // Baseline is the lowest RSSI since restart; a reading below it gives zero rise, not a wrap
    assign rise_db = (rssi_db > state_reg.rssi_base_reg) ? rssi_db - state_reg.rssi_base_reg
                                                         : 8'h00;
    assign rel_hit = (rise_db >= {4'h0, rise_step_db(rel_code)});
    assign level_thr = $signed({4'h0, setpoint_db}) + $signed({{6{abs_code[3]}}, abs_code});
    assign abs_hit = ($signed({2'b00, rssi_db}) >= level_thr);

    always_comb
    begin
        if (rel_on && abs_on)
            cs_next = rel_hit && abs_hit;
        else if (rel_on)
            cs_next = rel_hit;
        else if (abs_on)
            cs_next = abs_hit;
        else
            cs_next = 1'b0;
    end

    // ***************************************************************
    // Register port and state update
    // ***************************************************************
    always_comb
    begin
        state_next = state_reg;
        state_next.rd_valid_reg = reg_rd_en;
        if (reg_wr_en && reg_addr == `GLCS_ADDR_GAIN)
        begin
            state_next.gain_ceiling_and_target_reg = reg_wr_data;
        end
        if (reg_wr_en && reg_addr == `GLCS_ADDR_SENSE)
        begin
            state_next.gain_order_and_sense_thresholds_reg = reg_wr_data[6:0];
        end
        if (reg_rd_en)
        begin
            if (reg_addr == `GLCS_ADDR_GAIN)
                state_next.rd_data_reg = state_reg.gain_ceiling_and_target_reg;
            else if (reg_addr == `GLCS_ADDR_SENSE)
                state_next.rd_data_reg = {1'b0, state_reg.gain_order_and_sense_thresholds_reg};
            else
                state_next.rd_data_reg = 8'h00;
        end
        if (cs_restart || rssi_db < state_reg.rssi_base_reg)
            state_next.rssi_base_reg = rssi_db;
        // Restart drops the indication until the new baseline is judged
        state_next.cs_reg = cs_restart ? 1'b0 : cs_next;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg.gain_ceiling_and_target_reg <= `GLCS_GAIN_RESET;
            state_reg.gain_order_and_sense_thresholds_reg <= `GLCS_SENSE_RESET;
            state_reg.rssi_base_reg <= `GLCS_BASE_RESET;
            state_reg.cs_reg <= 1'b0;
            state_reg.rd_data_reg <= 8'h00;
            state_reg.rd_valid_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ***************************************************************
    // Outputs
    // ***************************************************************
    assign gain_cfg.digital_gain_ceiling =
        state_reg.gain_ceiling_and_target_reg[`GLCS_DGAIN_HI:`GLCS_DGAIN_LO];
    assign gain_cfg.front_gain_ceiling =
        state_reg.gain_ceiling_and_target_reg[`GLCS_FGAIN_HI:`GLCS_FGAIN_LO];
    assign gain_cfg.amplitude_setpoint =
        state_reg.gain_ceiling_and_target_reg[`GLCS_SETPT_HI:`GLCS_SETPT_LO];
    assign gain_cfg.gain_reduction_order =
        state_reg.gain_order_and_sense_thresholds_reg[`GLCS_ORDER_BIT];
    assign setpoint_db = setpoint_to_db(gain_cfg.amplitude_setpoint);
    assign carrier_sense = state_reg.cs_reg;
    assign reg_rd_data = state_reg.rd_data_reg;
    assign reg_rd_valid = state_reg.rd_valid_reg;

    // ***************************************************************
    // Assertions
    // ***************************************************************
    property p_dgain_write;
        @(posedge core_clk) disable iff (!rst_n)
        reg_wr_en && reg_addr == `GLCS_ADDR_GAIN
            |=> gain_cfg.digital_gain_ceiling == $past(reg_wr_data[7:6]);
    endproperty
    a_dgain_write: assert property (p_dgain_write) else $error("digital ceiling not stored");

    property p_fgain_write;
        @(posedge core_clk) disable iff (!rst_n)
        reg_wr_en && reg_addr == `GLCS_ADDR_GAIN
            |=> gain_cfg.front_gain_ceiling == $past(reg_wr_data[5:3]);
    endproperty
    a_fgain_write: assert property (p_fgain_write) else $error("front ceiling not stored");

    property p_setpoint_db;
        @(posedge core_clk) disable iff (!rst_n)
        (gain_cfg.amplitude_setpoint == 3'h5 |-> setpoint_db == 6'h26) and
        (gain_cfg.amplitude_setpoint == 3'h0 |-> setpoint_db == 6'h18);
    endproperty
    a_setpoint_db: assert property (p_setpoint_db) else $error("setpoint dB wrong");

    property p_order_write;
        @(posedge core_clk) disable iff (!rst_n)
        reg_wr_en && reg_addr == `GLCS_ADDR_SENSE
            |=> gain_cfg.gain_reduction_order == $past(reg_wr_data[`GLCS_ORDER_BIT]);
    endproperty
    a_order_write: assert property (p_order_write) else $error("order bit not stored");

    property p_order_hold;
        @(posedge core_clk) disable iff (!rst_n)
        !(reg_wr_en && reg_addr == `GLCS_ADDR_SENSE)
            |=> $stable(gain_cfg.gain_reduction_order);
    endproperty
    a_order_hold: assert property (p_order_hold) else $error("order changed without write");

    property p_reserved_zero;
        @(posedge core_clk) disable iff (!rst_n)
        reg_rd_en && reg_addr == `GLCS_ADDR_SENSE |=> reg_rd_valid && !reg_rd_data[7];
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

    property p_rel_only;
        @(posedge core_clk) disable iff (!rst_n)
        rel_on && !abs_on && !cs_restart |=> carrier_sense == $past(rel_hit);
    endproperty
    a_rel_only: assert property (p_rel_only) else $error("rise sensing wrong");

    property p_abs_only;
        @(posedge core_clk) disable iff (!rst_n)
        !rel_on && abs_on && !cs_restart |=> carrier_sense == $past(abs_hit);
    endproperty
    a_abs_only: assert property (p_abs_only) else $error("level sensing wrong");

    property p_abs_offset;
        @(posedge core_clk) disable iff (!rst_n)
        abs_code == 4'hF |-> level_thr == $signed({4'h0, setpoint_db}) - 10'sd1;
    endproperty
    a_abs_offset: assert property (p_abs_offset) else $error("offset not signed");

    property p_both_off;
        @(posedge core_clk) disable iff (!rst_n)
        rel_code == 2'h0 && abs_code == `GLCS_ABS_OFF |=> !carrier_sense;
    endproperty
    a_both_off: assert property (p_both_off) else $error("sense while disabled");

    property p_both_on;
        @(posedge core_clk) disable iff (!rst_n)
        rel_on && abs_on && !cs_restart |=> carrier_sense == $past(rel_hit && abs_hit);
    endproperty
    a_both_on: assert property (p_both_on) else $error("combined sensing wrong");

    c_rel_sense: cover property (@(posedge core_clk) disable iff (!rst_n)
        rel_on && !abs_on ##1 carrier_sense);
    c_abs_sense: cover property (@(posedge core_clk) disable iff (!rst_n)
        abs_on && !rel_on ##1 carrier_sense);
    c_both_sense: cover property (@(posedge core_clk) disable iff (!rst_n)
        rel_on && abs_on ##1 carrier_sense);

endmodule
`default_nettype wire

// ---- glcs_defs.svh ----
// Register offsets, field positions, reset values and the level sense off code of the gain loop config bank
`ifndef GLCS_DEFS_SVH
`define GLCS_DEFS_SVH

`define GLCS_ADDR_W 6
`define GLCS_ADDR_GAIN 6'h1B
`define GLCS_ADDR_SENSE 6'h1C

`define GLCS_DGAIN_HI 7
`define GLCS_DGAIN_LO 6
`define GLCS_FGAIN_HI 5
`define GLCS_FGAIN_LO 3
`define GLCS_SETPT_HI 2
`define GLCS_SETPT_LO 0
`define GLCS_ORDER_BIT 6
`define GLCS_REL_HI 5
`define GLCS_REL_LO 4
`define GLCS_ABS_HI 3
`define GLCS_ABS_LO 0

`define GLCS_GAIN_RESET 8'h03
`define GLCS_SENSE_RESET 7'h40
`define GLCS_ABS_OFF 4'h8
`define GLCS_BASE_RESET 8'hFF

`endif

// ---- glcs_pkg.sv ----
// Types shared by the gain loop and carrier sense configuration bank
`default_nettype none
package glcs_pkg;

    typedef struct packed {
        logic [1:0] digital_gain_ceiling;
        logic [2:0] front_gain_ceiling;
        logic [2:0] amplitude_setpoint;
        logic gain_reduction_order;
    } glcs_gain_cfg_s;

    typedef struct packed {
        logic [7:0] gain_ceiling_and_target_reg;
        logic [6:0] gain_order_and_sense_thresholds_reg;
        logic [7:0] rssi_base_reg;
        logic cs_reg;
        logic [7:0] rd_data_reg;
        logic rd_valid_reg;
    } glcs_state_s;

endpackage
`default_nettype wire

// ---- glcs_cfg_unused_note.sv ----
// Intentionally empty companion file
`default_nettype none
`default_nettype wire

// ---- glcs_cfg_test.sv ----
// Self-checking bench for the gain loop and carrier sense configuration bank
`include "glcs_defs.svh"
`default_nettype none
module glcs_cfg_test
    import glcs_pkg::*;
;
timeunit 1ns;
timeprecision 1ps;

logic core_clk;
logic rst_n;
logic [5:0] reg_addr;
logic reg_wr_en;
logic [7:0] reg_wr_data;
logic reg_rd_en;
logic [7:0] reg_rd_data;
logic reg_rd_valid;
logic [7:0] rssi_db;
logic cs_restart;
glcs_gain_cfg_s gain_cfg;
logic [5:0] setpoint_db;
logic carrier_sense;
int mismatches;
int checks_done;

glcs_cfg glcs_cfg_i (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
    .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .rssi_db(rssi_db),
    .cs_restart(cs_restart), .gain_cfg(gain_cfg), .setpoint_db(setpoint_db),
    .carrier_sense(carrier_sense));

always #20 core_clk = ~core_clk;

// ***************************************************************
// Helpers
// ***************************************************************
task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks_done++;
    if (seen !== exp)
    begin
        mismatches++;
        $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
endtask

task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
        $display("*** PASS ***");
    else
        $display("*** FAIL ***");
    $finish;
endtask

task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_en <= 1'b1;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
    #1;
endtask

// Valid is a one-cycle pulse, so it is looked at right after the taking edge
task automatic rdchk(input logic [5:0] a, input logic [7:0] exp, input string what);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge core_clk);
    reg_rd_en <= 1'b0;
    #1;
    chk({15'h0, reg_rd_valid}, 16'h1, "read valid");
    chk({8'h0, reg_rd_data}, {8'h0, exp}, what);
    @(posedge core_clk);
    #1;
    chk({15'h0, reg_rd_valid}, 16'h0, "read valid drops");
    chk({8'h0, reg_rd_data}, {8'h0, exp}, "read data holds");
endtask

function automatic int sp_db(input logic [2:0] c);
    case (c)
        3'h0: return 24;
        3'h1: return 27;
        3'h2: return 30;
        3'h3: return 33;
        3'h4: return 36;
        3'h5: return 38;
        3'h6: return 40;
        default: return 42;
    endcase
endfunction

function automatic logic cs_exp(input logic [1:0] rel, input logic [3:0] lvl,
    input logic [2:0] sp, input logic [7:0] b, input logic [7:0] v);
    int step;
    logic rel_ok;
    logic abs_ok;
    step = (rel == 2'h1) ? 6 : (rel == 2'h2) ? 10 : 14;
    rel_ok = int'(v) >= int'(b) + step;
    abs_ok = int'(v) >= sp_db(sp) + int'($signed(lvl));
    if (rel == 2'h0 && lvl == 4'h8)
        return 1'b0;
    if (rel == 2'h0)
        return abs_ok;
    if (lvl == 4'h8)
        return rel_ok;
    return rel_ok && abs_ok;
endfunction

// Restart sets the baseline to b, then v is held for one decision cycle
task automatic cs_try(input logic [7:0] b, input logic [7:0] v);
    @(posedge core_clk);
    cs_restart <= 1'b1;
    rssi_db <= b;
    @(posedge core_clk);
    cs_restart <= 1'b0;
    rssi_db <= v;
    #1;
    chk({15'h0, carrier_sense}, 16'h0, "restart clears sense");
    @(posedge core_clk);
    #1;
endtask

// ***************************************************************
// Main sequence
// ***************************************************************
initial
begin
    logic [7:0] d;
    logic [1:0] rel;
    logic [3:0] lvl;
    logic [7:0] b;
    logic [7:0] v;
    core_clk = 1'b0;
    rst_n = 1'b0;
    reg_addr = 6'h00;
    reg_wr_en = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en = 1'b0;
    rssi_db = 8'h00;
    cs_restart = 1'b0;
    mismatches = 0;
    checks_done = 0;
    void'($urandom(41977));
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    chk({7'h0, gain_cfg}, 16'h0007, "reset gain cfg");
    chk({10'h0, setpoint_db}, 16'd33, "reset setpoint");
    chk({15'h0, carrier_sense}, 16'h0, "reset sense");
    rdchk(`GLCS_ADDR_GAIN, 8'h03, "reset gain reg");
    rdchk(`GLCS_ADDR_SENSE, 8'h40, "reset sense reg");
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
        d = {i[1:0], 3'(7 - i), i[2:0]};
        wr(`GLCS_ADDR_GAIN, d);
        chk({7'h0, gain_cfg}, {7'h0, d, 1'b1}, "gain cfg fields");
        chk({10'h0, setpoint_db}, 16'(sp_db(i[2:0])), "setpoint dB");
        rdchk(`GLCS_ADDR_GAIN, d, "gain reg readback");
    end
    $display("test gain fields done");
    wr(`GLCS_ADDR_SENSE, 8'hBF);
    chk({15'h0, gain_cfg.gain_reduction_order}, 16'h0, "order cleared");
    rdchk(`GLCS_ADDR_SENSE, 8'h3F, "reserved bit reads zero");
    wr(6'h3F, 8'hAA);
    rdchk(`GLCS_ADDR_GAIN, d, "unmapped write ignored");
    rdchk(6'h1D, 8'h00, "unmapped read zero");
    $display("test sense reg done");
    for (int n = 0; n < 48; n++)
    begin
        rel = n[1:0];
        lvl = (n % 8 < 4) ? 4'h8 : 4'($urandom);
        d = 8'($urandom);
        wr(`GLCS_ADDR_GAIN, d);
        wr(`GLCS_ADDR_SENSE, {1'b0, n[2], rel, lvl});
        b = 8'(10 + $urandom % 30);
        v = (n % 3 == 0) ? 8'(b + 5 + rel * 4 + $urandom % 2) : 8'(b + $urandom % 21);
        cs_try(b, v);
        chk({15'h0, carrier_sense}, {15'h0, cs_exp(rel, lvl, d[2:0], b, v)},
            "carrier sense");
    end
    $display("test carrier sense done");
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    chk({15'h0, carrier_sense}, 16'h0, "mid-run reset sense");
    chk({7'h0, gain_cfg}, 16'h0007, "mid-run reset gain cfg");
    rdchk(`GLCS_ADDR_GAIN, 8'h03, "mid-run reset gain reg");
    rdchk(`GLCS_ADDR_SENSE, 8'h40, "mid-run reset sense reg");
    $display("test mid-run reset done");
    close_out();
end

initial
begin
    #2000000;
    mismatches++;
    $display("mismatch at %0t: run did not finish", $time);
    close_out();
end

endmodule
`default_nettype wire
